// >>> pkg/owpe_defs.vh
// Purpose: constants for the one-wire environment link originator
// Assumes: 32-bit bus words, register index times four is the byte address
// Notes: definitions only
`ifndef OWPE_DEFS_VH
`define OWPE_DEFS_VH

// register word indices
`define OWPE_REG_CTRL 4'h0
`define OWPE_REG_STAT 4'h1
`define OWPE_REG_NHC 4'h2
`define OWPE_REG_MBC 4'h3
`define OWPE_REG_STC 4'h4
`define OWPE_REG_TADR 4'h5
`define OWPE_REG_WLEN 4'h6
`define OWPE_REG_RLEN 4'h7
`define OWPE_REG_CWCK 4'h8
`define OWPE_REG_CRCK 4'h9
`define OWPE_REG_FIFO 4'hA

// link_control bits
`define OWPE_CTL_CLR 7
`define OWPE_CTL_EN 6
`define OWPE_CTL_ABT 5
`define OWPE_CTL_HWC 4
`define OWPE_CTL_STOP 3

// link_status bits
`define OWPE_ST_BUSY 7
`define OWPE_ST_RFULL 1

// reset values
`define OWPE_RST_NHC 16'h0000
`define OWPE_RST_MBC 16'hFFFF
`define OWPE_RST_STC 16'hFFFF

// frame check polynomial x^8 + x^2 + x + 1
`define OWPE_CRC_POLY 8'h07

`endif

// >>> src/owpe_originator.v
// Purpose: originator for a one-wire processor environment control link
// Assumes: Avalon-MM slave with waitrequest, one clock, sync reset
// Notes: bit period is four quarters of (measured count + 1) clocks;
//        a zero is one quarter high, a one three quarters high
//
// Behaviour
// - soft clear resets sequencer, then setup wait
// - enable bit gates all link operation
// - abort on check error when enabled
// - bit four turns on host write check
// - stop bit appends message stop period
// - three enables gate the three interrupts
// - busy set at start, cleared at end
// - check errors set sticky, read-one-write-zero clear
// - transfer end flag set after whole transfer
// - negotiation done flags, read-one-write-zero clear
// - receive full set, cleared after all read
// - status bit zero mirrors pin level
// - negotiation high lasts pre-count plus one
// - measured count register, resets all ones
// - setup count replaced by first measurement
// - setup timing starts when link enabled
// - target address write starts, sometimes ignored
// - write length reads zero after transfer
// - read length counts down per fifo read
// - one fifo address for send and receive
// - client check bytes captured read-only
// - crc polynomial x8+x2+x+1, compare for good
// - host check byte is crc, msb inverted
`timescale 1ns/1ps
`include "owpe_defs.vh"

module owpe_originator #(
  parameter FIFO_AW = 5
) (
  input wire clk_i,
  input wire srst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire pin_i,
  output reg pin_o,
  output reg pin_oe_o,
  output reg irq_o
);

  localparam ST_OFF = 4'h0;
  localparam ST_SETUP = 4'h1;
  localparam ST_READY = 4'h2;
  localparam ST_ADDRESS_NEGOTIATION_DONE = 4'h3;
  localparam ST_ADDR = 4'h4;
  localparam ST_MESSAGE_NEGOTIATION_DONE = 4'h5;
  localparam ST_WLEN = 4'h6;
  localparam ST_RLEN = 4'h7;
  localparam ST_WDATA = 4'h8;
  localparam ST_HWCK = 4'h9;
  localparam ST_RWCK = 4'hA;
  localparam ST_RDATA = 4'hB;
  localparam ST_RRCK = 4'hC;
  localparam ST_STOP = 4'hD;

  // one crc step per link bit, msb first
  function [7:0] crc_step;
    input [7:0] c;
    input b;
    begin
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `OWPE_CRC_POLY : 8'h00);
    end
  endfunction

  reg pin_m;
  reg pin_s;
  reg [6:0] ctrl;
  reg busy;
  reg rfull;
  reg [4:0] flg; // wr err, rd err, end, addr neg, msg neg
  reg [4:0] seen;
  reg [15:0] nhc;
  reg [15:0] mbc;
  reg [15:0] stc;
  reg [7:0] tadr;
  reg [7:0] wlen;
  reg [7:0] rlen;
  reg [7:0] cwck;
  reg [7:0] crck;
  reg [7:0] mem [0:(1<<FIFO_AW)-1];
  reg [FIFO_AW-1:0] wp;
  reg [FIFO_AW-1:0] rp;
  reg [3:0] state;
  reg [19:0] cnt;
  reg [2:0] bit_idx;
  reg [7:0] sh;
  reg [7:0] crc;
  reg [7:0] chk;
  reg [7:0] bytes_left;
  reg rx_bit;
  reg neg_rel;
  reg first;
  reg start_req;
  reg [31:0] rd_mux;

  wire req = avs_read_i | avs_write_i;
  wire acc_wr = avs_write_i & ~avs_waitrequest_o;
  wire acc_rd = avs_read_i & ~avs_waitrequest_o;
  wire be0 = avs_byteenable_i[0];
  wire be1 = avs_byteenable_i[1];
  wire [31:0] wd = avs_writedata_i;
  wire wr_ctrl = acc_wr & be0 & (avs_address_i == `OWPE_REG_CTRL);
  wire soft_clr = wr_ctrl & wd[`OWPE_CTL_CLR];
  wire en = ctrl[`OWPE_CTL_EN];
  wire [7:0] status = {busy, flg, rfull, pin_s};
  wire [19:0] q1 = {4'h0, mbc} + 20'h00001;
  wire [19:0] q2 = {q1[18:0], 1'b0};
  wire [19:0] q3 = q1 + q2;
  wire [19:0] q4 = {q1[17:0], 2'b00};
  wire [19:0] setup_lim = {2'b00, stc, 2'b00} + 20'h00004;
  wire is_tx = (state == ST_ADDR) | (state == ST_WLEN) |
               (state == ST_RLEN) | (state == ST_WDATA) |
               (state == ST_HWCK);
  wire is_rx = (state == ST_RWCK) | (state == ST_RDATA) |
               (state == ST_RRCK);
  wire bit_v = is_tx ? sh[7] : rx_bit;
  wire [7:0] nb = {sh[6:0], bit_v};
  wire [7:0] crc_n = crc_step(crc, bit_v);
  wire [7:0] hwck = {~crc_n[7], crc_n[6:0]};

  // pin synchroniser; second stage is the only reader of the first
  always @(posedge clk_i) begin
    pin_m <= pin_i;
    pin_s <= pin_m;
  end

  // read data selection
  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      `OWPE_REG_CTRL: rd_mux[6:0] = ctrl;
      `OWPE_REG_STAT: rd_mux[7:0] = status;
      `OWPE_REG_NHC: rd_mux[15:0] = nhc;
      `OWPE_REG_MBC: rd_mux[15:0] = mbc;
      `OWPE_REG_STC: rd_mux[15:0] = stc;
      `OWPE_REG_TADR: rd_mux[7:0] = tadr;
      `OWPE_REG_WLEN: rd_mux[7:0] = wlen;
      `OWPE_REG_RLEN: rd_mux[7:0] = rlen;
      `OWPE_REG_CWCK: rd_mux[7:0] = cwck;
      `OWPE_REG_CRCK: rd_mux[7:0] = crck;
      `OWPE_REG_FIFO: rd_mux[7:0] = mem[rp];
      default: rd_mux = 32'h00000000;
    endcase
  end

  // bus handshake: one wait cycle, then data and waitrequest low
  always @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

  // combined interrupt, registered so the output is a flop
  always @(posedge clk_i) begin
    if (srst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(flg[4:2] & ctrl[2:0]);
  end

  // registers and sequencer share one process so each has one driver;
  // bus effects come first so a hardware set in the same cycle wins
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= 7'h00;
      busy <= 1'b0;
      rfull <= 1'b0;
      flg <= 5'h00;
      seen <= 5'h00;
      nhc <= `OWPE_RST_NHC;
      mbc <= `OWPE_RST_MBC;
      stc <= `OWPE_RST_STC;
      tadr <= 8'h00;
      wlen <= 8'h00;
      rlen <= 8'h00;
      cwck <= 8'h00;
      crck <= 8'h00;
      wp <= {FIFO_AW{1'b0}};
      rp <= {FIFO_AW{1'b0}};
      state <= ST_OFF;
      cnt <= 20'h00000;
      bit_idx <= 3'h0;
      sh <= 8'h00;
      crc <= 8'h00;
      chk <= 8'h00;
      bytes_left <= 8'h00;
      rx_bit <= 1'b0;
      neg_rel <= 1'b0;
      first <= 1'b1;
      start_req <= 1'b0;
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      // software writes
      if (wr_ctrl)
        ctrl <= wd[6:0];
      if (acc_wr && avs_address_i == `OWPE_REG_STAT && be0) begin
        flg <= flg & ~(seen & ~wd[6:2]);
        seen <= seen & wd[6:2];
      end
      if (acc_rd && avs_address_i == `OWPE_REG_STAT)
        seen <= seen | flg;
      if (acc_wr && avs_address_i == `OWPE_REG_NHC) begin
        if (be0) nhc[7:0] <= wd[7:0];
        if (be1) nhc[15:8] <= wd[15:8];
      end
      if (acc_wr && avs_address_i == `OWPE_REG_STC) begin
        if (be0) stc[7:0] <= wd[7:0];
        if (be1) stc[15:8] <= wd[15:8];
      end
      if (acc_wr && be0 && avs_address_i == `OWPE_REG_TADR) begin
        tadr <= wd[7:0];
        if (en && !rfull && !busy)
          start_req <= 1'b1;
      end
      if (acc_wr && be0 && avs_address_i == `OWPE_REG_WLEN)
        wlen <= wd[7:0];
      if (acc_wr && be0 && avs_address_i == `OWPE_REG_RLEN)
        rlen <= wd[7:0];
      if (acc_wr && be0 && avs_address_i == `OWPE_REG_FIFO) begin
        mem[wp] <= wd[7:0];
        wp <= wp + 1'b1;
      end
      // fifo pop after the transfer counts the read length down
      if (acc_rd && avs_address_i == `OWPE_REG_FIFO && !busy) begin
        rp <= rp + 1'b1;
        if (rlen != 8'h00)
          rlen <= rlen - 8'h01;
        if (rlen == 8'h01)
          rfull <= 1'b0;
      end

      if (soft_clr) begin
        // sequencer and flags restart; setup is timed again
        state <= wd[`OWPE_CTL_EN] ? ST_SETUP : ST_OFF;
        cnt <= 20'h00000;
        busy <= 1'b0;
        rfull <= 1'b0;
        flg <= 5'h00;
        seen <= 5'h00;
        cwck <= 8'h00;
        crck <= 8'h00;
        start_req <= 1'b0;
        if (en)
          mbc <= stc;
      end else if (!en) begin
        state <= ST_OFF;
        pin_oe_o <= 1'b0;
        busy <= 1'b0;
        start_req <= 1'b0;
      end else begin
        case (state)
          ST_OFF: begin
            state <= ST_SETUP;
            cnt <= 20'h00000;
          end
          ST_SETUP: begin
            pin_oe_o <= 1'b1;
            pin_o <= 1'b0;
            cnt <= cnt + 20'h00001;
            if (cnt >= setup_lim)
              state <= ST_READY;
          end
          ST_READY: begin
            pin_oe_o <= 1'b1;
            pin_o <= 1'b0;
            cnt <= 20'h00000;
            neg_rel <= 1'b0;
            if (start_req) begin
              start_req <= 1'b0;
              busy <= 1'b1;
              rp <= {FIFO_AW{1'b0}};
              state <= ST_ADDRESS_NEGOTIATION_DONE;
            end
          end
          ST_ADDRESS_NEGOTIATION_DONE, ST_MESSAGE_NEGOTIATION_DONE: begin
            // drive high, release, time how long the wire stays high;
            // a client that never lets go needs a soft clear
            cnt <= cnt + 20'h00001;
            if (!neg_rel) begin
              pin_oe_o <= 1'b1;
              pin_o <= 1'b1;
              if (cnt[15:0] == nhc && cnt[19:16] == 4'h0)
                neg_rel <= 1'b1;
            end else begin
              pin_oe_o <= 1'b0;
              if (!pin_s) begin
                mbc <= cnt[15:0];
                cnt <= 20'h00000;
                bit_idx <= 3'h0;
                neg_rel <= 1'b0;
                if (state == ST_ADDRESS_NEGOTIATION_DONE) begin
                  flg[1] <= 1'b1;
                  if (first) begin
                    stc <= cnt[15:0];
                    first <= 1'b0;
                  end
                  sh <= tadr;
                  crc <= 8'h00;
                  state <= ST_ADDR;
                end else begin
                  flg[0] <= 1'b1;
                  sh <= wlen;
                  state <= ST_WLEN;
                end
              end
            end
          end
          ST_STOP: begin
            pin_oe_o <= 1'b1;
            pin_o <= 1'b0;
            cnt <= cnt + 20'h00001;
            if (cnt == {q4[18:0], 1'b0}) begin
              busy <= 1'b0;
              flg[2] <= 1'b1;
              wlen <= 8'h00;
              rfull <= (rlen != 8'h00);
              rp <= {FIFO_AW{1'b0}};
              wp <= {FIFO_AW{1'b0}};
              state <= ST_READY;
            end
          end
          default: begin
            if (is_tx || is_rx) begin
              // one bit cell: tx shapes the high time, rx samples mid
              cnt <= cnt + 20'h00001;
              pin_o <= 1'b1;
              if (is_tx) begin
                pin_oe_o <= 1'b1;
                pin_o <= cnt < (sh[7] ? q3 : q1);
              end else begin
                pin_oe_o <= cnt < q1;
              end
              if (cnt == q2)
                rx_bit <= pin_s;
              if (cnt == q4 - 20'h00001) begin
                cnt <= 20'h00000;
                crc <= crc_n;
                sh <= nb;
                bit_idx <= bit_idx + 3'h1;
                if (bit_idx == 3'h7) begin
                  case (state)
                    ST_ADDR: state <= ST_MESSAGE_NEGOTIATION_DONE;
                    ST_WLEN: begin
                      sh <= rlen;
                      state <= ST_RLEN;
                    end
                    ST_RLEN, ST_WDATA: begin
                      if (state == ST_RLEN)
                        bytes_left <= wlen;
                      if ((state == ST_RLEN && wlen != 8'h00) ||
                          (state == ST_WDATA && bytes_left != 8'h00)) begin
                        sh <= mem[rp];
                        rp <= rp + 1'b1;
                        bytes_left <= (state == ST_RLEN ? wlen : bytes_left)
                                      - 8'h01;
                        state <= ST_WDATA;
                      end else if (state == ST_RLEN) begin
                        state <= ST_STOP; // no data: ping
                        cnt <= ctrl[`OWPE_CTL_STOP] ? 20'h00000
                                                    : {q4[18:0], 1'b0};
                      end else if (ctrl[`OWPE_CTL_HWC]) begin
                        sh <= hwck;
                        state <= ST_HWCK;
                      end else begin
                        chk <= crc_n;
                        state <= ST_RWCK;
                      end
                    end
                    ST_HWCK: begin
                      chk <= crc_n;
                      state <= ST_RWCK;
                    end
                    ST_RWCK: begin
                      cwck <= nb;
                      crc <= 8'h00;
                      wp <= {FIFO_AW{1'b0}};
                      bytes_left <= rlen;
                      if (nb != chk)
                        flg[4] <= 1'b1;
                      if (nb != chk && ctrl[`OWPE_CTL_ABT]) begin
                        busy <= 1'b0;
                        rfull <= 1'b0;
                        cnt <= 20'h00000;
                        state <= ST_SETUP;
                      end else if (rlen != 8'h00) begin
                        state <= ST_RDATA;
                      end else begin
                        state <= ST_STOP;
                        cnt <= ctrl[`OWPE_CTL_STOP] ? 20'h00000
                                                    : {q4[18:0], 1'b0};
                      end
                    end
                    ST_RDATA: begin
                      mem[wp] <= nb;
                      wp <= wp + 1'b1;
                      chk <= crc_n;
                      bytes_left <= bytes_left - 8'h01;
                      if (bytes_left == 8'h01)
                        state <= ST_RRCK;
                    end
                    default: begin
                      crck <= nb;
                      if (nb != chk)
                        flg[3] <= 1'b1;
                      if (nb != chk && ctrl[`OWPE_CTL_ABT]) begin
                        busy <= 1'b0;
                        rfull <= 1'b0;
                        cnt <= 20'h00000;
                        state <= ST_SETUP;
                      end else begin
                        state <= ST_STOP;
                        cnt <= ctrl[`OWPE_CTL_STOP] ? 20'h00000
                                                    : {q4[18:0], 1'b0};
                      end
                    end
                  endcase
                end
              end
            end else begin
              state <= ST_SETUP;
              cnt <= 20'h00000;
            end
          end
        endcase
      end
    end
  end

endmodule

// >>> verif/owpe_originator_assertions.sv
// Purpose: port-level checks for the link originator
// Assumes: one clock, sync reset; control is shadowed from bus writes
// Notes: the shadow cannot see soft-clear effects, so bounds are loose
`timescale 1ns/1ps
`include "owpe_defs.vh"
module owpe_originator_assertions (
  input wire clk_i,
  input wire srst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire pin_i,
  input wire pin_o,
  input wire pin_oe_o,
  input wire irq_o
);
  reg [7:0] ctl;
  reg [15:0] stc;
  reg [19:0] since_en;
  reg pin_q;
  reg [2:0] pin_st;
  wire acc = !avs_waitrequest_o;
  wire wr_ok = avs_write_i && acc && avs_byteenable_i[0];
  wire rd_ok = avs_read_i && acc;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // shadow control and setup count; pin stability feeds the monitor check
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctl <= 8'h00;
      stc <= 16'hFFFF;
      since_en <= 20'h00000;
      pin_st <= 3'h0;
    end else begin
      if (wr_ok && avs_address_i == `OWPE_REG_CTRL)
        ctl <= {1'b0, avs_writedata_i[6:0]};
      if (wr_ok && avs_address_i == `OWPE_REG_STC)
        stc <= avs_writedata_i[15:0];
      since_en <= ctl[6] ? since_en + {19'h0, ~&since_en} : 20'h00000;
      pin_st <= (pin_i != pin_q) ? 3'h0 : pin_st + {2'h0, pin_st != 3'h5};
    end
    pin_q <= pin_i;
  end
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_one_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) srst_i |=>
    avs_waitrequest_o && !pin_oe_o && !irq_o)
    else $error("outputs not quiet after reset");
  chk_one_wait: assert property (s_req_wait |=> s_one_answer)
    else $error("bus answer not exactly one wait cycle");
  chk_no_stray_ack: assert property (acc |-> $past(avs_read_i || avs_write_i))
    else $error("answer without a request");
  chk_unmapped_zero: assert property (rd_ok && avs_address_i > 4'hA |->
    avs_readdata_o == 32'h00000000) else $error("unmapped read not zero");
  chk_clear_bit_low: assert property (
    rd_ok && avs_address_i == `OWPE_REG_CTRL |-> avs_readdata_o[31:7] == 25'h0)
    else $error("control clear bit reads one");
  chk_pin_mirror: assert property (
    rd_ok && avs_address_i == `OWPE_REG_STAT && pin_st == 3'h5 |->
    avs_readdata_o[0] == $past(pin_i, 3)) else $error("pin monitor wrong");
  chk_irq_masked: assert property (
    ctl[2:0] == 3'h0 && $past(ctl[2:0]) == 3'h0 |-> !irq_o)
    else $error("irq with all enables off");
  chk_link_off: assert property (
    !ctl[6] && !$past(ctl[6]) && !$past(ctl[6], 2) |-> !pin_oe_o)
    else $error("wire driven while link disabled");
  chk_setup_hold: assert property (
    ctl[6] && since_en < {stc, 2'b00} |-> !(pin_oe_o && pin_o))
    else $error("wire high inside setup time");
endmodule
bind owpe_originator owpe_originator_assertions u_chk (.clk_i(clk_i),
  .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .irq_o(irq_o));

// >>> verif/owpe_client_model.sv
// Purpose: behavioural client on the link wire
// Assumes: wire pulled low when nobody drives it
// Notes: a released high is held for hold_i cycles, under a quarter bit, so reads return zeros
`timescale 1ns/1ps
module owpe_client_model (
  input wire clk_i,
  input wire srst_i,
  input wire host_o_i,
  input wire host_oe_i,
  input wire [7:0] hold_i,
  output wire wire_o
);
  reg drive;
  reg last_hi;
  reg [7:0] left;
  // host wins; last_hi bridges the cycle before the client takes over
  assign wire_o = host_oe_i ? host_o_i : (drive | last_hi);
  // stretch a released high so the host can time the bit period
  always @(posedge clk_i) begin
    if (srst_i) begin
      drive <= 1'b0;
      last_hi <= 1'b0;
      left <= 8'h00;
    end else begin
      last_hi <= host_oe_i & host_o_i;
      if (last_hi && !host_oe_i && hold_i != 8'h00) begin
        drive <= 1'b1;
        left <= hold_i;
      end else if (left > 8'h01) begin
        left <= left - 8'h01;
      end else begin
        drive <= 1'b0;
        left <= 8'h00;
      end
    end
  end
endmodule

// >>> verif/one_wire_processor_env_originator_test.sv
// Purpose: self-checking bench for the link originator
// Assumes: small setup count keeps the run short
// Notes: checked reads leave a note in a queue; a monitor compares them
`timescale 1ns/1ps
`include "owpe_defs.vh"
module one_wire_processor_env_originator_test;
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg nt = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [7:0] hold = 8'h02;
  reg [31:0] got;
  reg [31:0] v;
  reg [31:0] m;
  reg [31:0] eq[$];
  reg [31:0] mq[$];
  wire [31:0] rdat;
  wire wreq;
  wire p_o;
  wire p_oe;
  wire irq;
  wire line;
  integer miscompares = 0;
  integer checks = 0;
  integer seed = 66101;
  integer i;
  owpe_originator DUT (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .pin_i(line), .pin_o(p_o), .pin_oe_o(p_oe),
    .irq_o(irq));
  owpe_client_model u_cli (.clk_i(clk_i), .srst_i(srst_i), .host_o_i(p_o),
    .host_oe_i(p_oe), .hold_i(hold), .wire_o(line));
  // 200 MHz system clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task close_out;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task bus(input w, input [3:0] a, input [31:0] d, input c);
    integer n;
    begin
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      nt <= c;
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (wreq !== 1'b0 && n < 50);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) cmp(n, 0);
    end
  endtask
  task rdc(input [3:0] a, input [31:0] e, input [31:0] k);
    begin
      eq.push_back(e);
      mq.push_back(k);
      bus(1'b0, a, 32'h0, 1'b1);
    end
  endtask
  task wait_busy(input b);
    integer n;
    begin
      n = 0;
      got = {24'h0, !b, 7'h0};
      while (got[7] !== b && n < 3000) begin
        bus(1'b0, `OWPE_REG_STAT, 32'h0, 1'b0);
        n = n + 1;
      end
      cmp(got[7], b);
    end
  endtask
  // read monitor: the oldest note belongs to this answer
  always @(posedge clk_i) begin
    if (rd && nt && wreq === 1'b0) begin
      cmp(rdat & mq[0], eq[0] & mq[0]);
      eq.delete(0);
      mq.delete(0);
    end
  end
  // watchdog sized well above the longest transfer
  initial begin
    repeat (60000) @(posedge clk_i);
    cmp(0, 1);
    close_out;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset table; fifo read but not compared, so its read pointer advances once
    for (i = 0; i < 16; i = i + 1) begin
      v = (i == 3 || i == 4) ? 32'hFFFF : 32'h0;
      m = (i == 1) ? 32'hFE : (i == 10) ? 32'h0 : 32'hFFFFFFFF;
      rdc(i[3:0], v, m);
    end
    // random in-range values; read-only words keep their contents
    for (i = 2; i < 9; i = i + 1) begin
      v = $unsigned($random(seed)) % 32 + 1;
      m = (i == 3) ? 32'hFFFF : (i == 8) ? 32'h0 : v;
      if (i != 5) bus(1'b1, i[3:0], v, 1'b0);
      if (i != 5) rdc(i[3:0], m, 32'hFFFF);
    end
    bus(1'b1, `OWPE_REG_TADR, 32'h5A, 1'b0);
    rdc(`OWPE_REG_STAT, 32'h0, 32'h80);
    for (i = 0; i < 4; i = i + 1) begin
      v = ($random(seed) & 32'h3F) | 32'h80;
      bus(1'b1, `OWPE_REG_CTRL, v, 1'b0);
      rdc(`OWPE_REG_CTRL, v & 32'h3F, 32'hFF);
      cmp(irq, 0);
    end
    // prompt client, ping with stop period and all interrupts on
    bus(1'b1, `OWPE_REG_NHC, 32'h3, 1'b0);
    bus(1'b1, `OWPE_REG_STC, 32'h4, 1'b0);
    bus(1'b1, `OWPE_REG_WLEN, 32'h0, 1'b0);
    bus(1'b1, `OWPE_REG_RLEN, 32'h0, 1'b0);
    bus(1'b1, `OWPE_REG_CTRL, 32'h4F, 1'b0);
    bus(1'b1, `OWPE_REG_TADR, 32'h30, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdc(`OWPE_REG_STAT, 32'h1C, 32'hFE);
    rdc(`OWPE_REG_WLEN, 32'h0, 32'hFF);
    cmp(irq, 1);
    bus(1'b1, `OWPE_REG_CTRL, 32'h4E, 1'b0);
    repeat (3) @(posedge clk_i);
    cmp(irq, 0);
    bus(1'b1, `OWPE_REG_STAT, 32'hFF, 1'b0);
    rdc(`OWPE_REG_STAT, 32'h1C, 32'hFE);
    bus(1'b1, `OWPE_REG_STAT, 32'h0, 1'b0);
    rdc(`OWPE_REG_STAT, 32'h0, 32'hFE);
    // slow client, two write bytes with host check byte, two read bytes
    hold <= 8'h0C;
    bus(1'b1, `OWPE_REG_WLEN, 32'h2, 1'b0);
    bus(1'b1, `OWPE_REG_RLEN, 32'h2, 1'b0);
    bus(1'b1, `OWPE_REG_FIFO, 32'h01, 1'b0);
    bus(1'b1, `OWPE_REG_FIFO, 32'hA5, 1'b0);
    bus(1'b1, `OWPE_REG_CTRL, 32'h5F, 1'b0);
    bus(1'b1, `OWPE_REG_TADR, 32'h30, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdc(`OWPE_REG_STAT, 32'h1E, 32'h9E);
    bus(1'b1, `OWPE_REG_TADR, 32'h30, 1'b0);
    repeat (10) @(posedge clk_i);
    rdc(`OWPE_REG_STAT, 32'h02, 32'h82);
    rdc(`OWPE_REG_RLEN, 32'h2, 32'hFF);
    bus(1'b0, `OWPE_REG_FIFO, 32'h0, 1'b0);
    rdc(`OWPE_REG_RLEN, 32'h1, 32'hFF);
    bus(1'b0, `OWPE_REG_FIFO, 32'h0, 1'b0);
    rdc(`OWPE_REG_RLEN, 32'h0, 32'hFF);
    rdc(`OWPE_REG_STAT, 32'h0, 32'h02);
    // soft clear in mid transfer, then a fresh ping must still run
    bus(1'b1, `OWPE_REG_WLEN, 32'h0, 1'b0);
    bus(1'b1, `OWPE_REG_RLEN, 32'h0, 1'b0);
    bus(1'b1, `OWPE_REG_TADR, 32'h30, 1'b0);
    wait_busy(1'b1);
    bus(1'b1, `OWPE_REG_CTRL, 32'hCF, 1'b0);
    rdc(`OWPE_REG_STAT, 32'h0, 32'hFE);
    rdc(`OWPE_REG_CRCK, 32'h0, 32'hFF);
    bus(1'b1, `OWPE_REG_TADR, 32'h30, 1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    // second reset in mid run
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rdc(`OWPE_REG_CTRL, 32'h0, 32'hFF);
    rdc(`OWPE_REG_STC, 32'hFFFF, 32'hFFFF);
    close_out;
  end
endmodule
